// ===== rtl/dcr_regs.svh
`ifndef DCR_REGS_SVH
`define DCR_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DCR_OFS_MAIN_CONTROL 4'h0
`define DCR_OFS_AUX_CONTROL 4'h1
`define DCR_OFS_MOD_CODE_LOW 4'h2
`define DCR_OFS_MOD_CODE_HIGH 4'h3
`define DCR_OFS_BIAS_CODE_LOW 4'h4
`define DCR_OFS_BIAS_CODE_HIGH 4'h5
`define DCR_OFS_CONV_RESULT_HIGH 4'hE
`define DCR_OFS_CONV_RESULT_LOW 4'hF

// ----------------------------------------
// main control fields
// ----------------------------------------
`define DCR_BIT_CHIP_ON 7
`define DCR_BIT_PD_RANGE_HI 6
`define DCR_BIT_PD_RANGE_LO 5
`define DCR_BIT_OPEN_LOOP 4
`define DCR_BIT_FAULT_DETECT 3
`define DCR_BIT_OUT_INVERT 2
`define DCR_BIT_EQ_ON 1
`define DCR_BIT_PD_ORIENT 0

// ----------------------------------------
// auxiliary control fields
// ----------------------------------------
`define DCR_BIT_SER_TERM 7
`define DCR_BIT_STRONG_FOLLOWER 6
`define DCR_BIT_EQ_HIGH_GAIN 5
`define DCR_BIT_HIGH_MOD_DRIVE 4
`define DCR_BIT_OFFSET_CANCEL_OFF 3
`define DCR_BIT_BIAS_DIRECTION 2
`define DCR_BIT_SHUTDOWN_STYLE 1
`define DCR_BIT_INPUT_LOW_GAIN 0

// ----------------------------------------
// reset values and scale figures
// ----------------------------------------
`define DCR_RST_BYTE 8'h00
`define DCR_RST_PAIR 2'h0
`define DCR_LOW_PAIR_MASK 8'h03
`define DCR_OL_SOURCE_UA 18'h0_0096
`define DCR_OL_SINK_UA 18'h0_0064
`define DCR_MOD_STEP_HALF_MV 13'h0005
`define DCR_MOD_MAX_HALF_MV 13'h11F8

`endif

// ===== rtl/dcr_pkg.sv
package dcr_pkg;

    typedef enum logic [1:0] {
        DCR_PD_RANGE_770 = 2'b00,
        DCR_PD_RANGE_1540 = 2'b01,
        DCR_PD_RANGE_3080 = 2'b10,
        DCR_PD_RANGE_3080_ALT = 2'b11
    } dcr_pd_range_e;

    typedef logic [9:0] dcr_code_t;

    typedef struct packed {
        logic [7:0] main_ctl;
        logic [7:0] aux_ctl;
        logic [1:0] mod_lo;
        logic [7:0] mod_hi;
        logic [1:0] bias_lo;
        logic [7:0] bias_hi;
        logic [7:0] rd_data;
        logic rd_valid;
    } dcr_bank_s;

    typedef struct packed {
        logic pin_meta;
        logic pin_sync;
        logic chip_on_prev;
        logic fault;
    } dcr_fault_s;

endpackage

// ===== rtl/dcr_fault_if.sv
`timescale 1ns/10ps
`default_nettype none

interface dcr_fault_if;
    logic chip_on;
    logic detect_on;
    logic fault_latched;

    modport ctl (output chip_on, output detect_on, input fault_latched);
    modport mon (input chip_on, input detect_on, output fault_latched);
endinterface

`default_nettype wire

// ===== rtl/dcr_fault_latch.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcr_regs.svh"

module dcr_fault_latch (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // fault comparator pin
    input wire logic fault_pin_i,
    // control side
    dcr_fault_if.mon flt
);
    import dcr_pkg::*;

    dcr_fault_s state_reg;
    dcr_fault_s state_next;

    // ----------------------------------------
    // fault capture
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.pin_meta = fault_pin_i;
        state_next.pin_sync = state_reg.pin_meta;
        state_next.chip_on_prev = flt.chip_on;
        // chip_on falling clears; a fault in that cycle cannot set, since chip_on is already low
        if (state_reg.chip_on_prev && !flt.chip_on) begin // see R1
            state_next.fault = 1'b0;
        end
        if (flt.detect_on && flt.chip_on && state_reg.pin_sync) begin // see R4
            state_next.fault = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    assign flt.fault_latched = state_reg.fault;

endmodule

`default_nettype wire

// ===== rtl/dcr_reg_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcr_regs.svh"

// What this block does
// R1 - chip_on 1 runs the driver, 0 disables; toggling it low clears latched fault
// R2 - photodiode range selects 3080, 1540 or 770 uA full scale
// R3 - open_loop_select 1 gives open loop bias, 0 closed power loop
// R4 - faults are detected only while fault_detect_on is 1
// R5 - output_invert swaps positive and negative output pins
// R6 - equalizer_on 1 enables equalizer, 0 bypasses it
// R7 - photodiode_orientation 1 cathode to supply, 0 anode to ground
// R8 - serial_input_termination picks 40k when set, 10k when clear
// R9 - strong_follower_drive enables high emitter follower current
// R10 - equalizer_high_gain raises equalizer gain only while equalizer is on
// R11 - high_modulation_drive enables high modulation current
// R12 - offset_cancel_off 1 disables DC offset cancellation
// R13 - bias_direction 1 makes bias pin sink, 0 source
// R14 - shutdown_style 1 turns off output stage only, 0 most of path
// R15 - input_low_gain reduces input gain only while equalizer is off
// R16 - modulation code joins register 3 high bits and register 2 low bits
// R17 - bias code joins registers 5 and 4; closed-loop target is step times code
// R18 - open loop bias is code times 150 uA source, 100 uA sink
// R19 - register 15 returns converter result bits 1 to 0, read-only
// R20 - register 14 returns converter result bits 9 to 2, read-only
// R21 - unused bits ignore writes and read as zero

module dcr_reg_bank (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // register port from serial control logic
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wr_data_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    // converter and fault inputs
    input wire dcr_pkg::dcr_code_t conv_result_i,
    input wire logic fault_pin_i,
    // run and fault state
    output logic driver_run_o,
    output logic fault_o,
    output logic output_stage_off_o,
    output logic signal_path_off_o,
    // loop and monitor setup
    output dcr_pkg::dcr_pd_range_e photodiode_range_o,
    output logic open_loop_o,
    output logic closed_loop_o,
    output logic photodiode_orientation_o,
    // signal path options
    output logic output_invert_o,
    output logic equalizer_on_o,
    output logic equalizer_bypass_o,
    output logic equalizer_high_gain_o,
    output logic input_low_gain_o,
    output logic offset_cancel_on_o,
    // drive options
    output logic serial_input_termination_o,
    output logic strong_follower_drive_o,
    output logic high_modulation_drive_o,
    output logic bias_sink_o,
    // codes and derived targets
    output dcr_pkg::dcr_code_t modulation_code_o,
    output logic [12:0] modulation_swing_half_mv_o,
    output dcr_pkg::dcr_code_t bias_code_o,
    output logic [11:0] closed_loop_target_steps_o,
    output logic [17:0] open_loop_bias_ua_o
);
    import dcr_pkg::*;

    dcr_bank_s state_reg;
    dcr_bank_s state_next;
    dcr_fault_if flt ();

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic dcr_code_t join_code(input logic [7:0] hi, input logic [1:0] lo);
        join_code = {hi, lo};
    endfunction

    function automatic logic [7:0] pad_pair(input logic [1:0] lo);
        pad_pair = {6'h00, lo};
    endfunction

    function automatic logic [17:0] ua_scale(input dcr_code_t code, input logic [17:0] per_step);
        ua_scale = 18'(code) * per_step;
    endfunction

    // ----------------------------------------
    // register writes and reads
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.rd_valid = 1'b0;
        if (wr_en_i) begin
            case (addr_i)
                `DCR_OFS_MAIN_CONTROL: begin
                    state_next.main_ctl = wr_data_i;
                end
                `DCR_OFS_AUX_CONTROL: begin
                    state_next.aux_ctl = wr_data_i;
                end
                `DCR_OFS_MOD_CODE_LOW: begin
                    state_next.mod_lo = wr_data_i[1:0]; // see R21
                end
                `DCR_OFS_MOD_CODE_HIGH: begin
                    state_next.mod_hi = wr_data_i;
                end
                `DCR_OFS_BIAS_CODE_LOW: begin
                    state_next.bias_lo = wr_data_i[1:0]; // see R21
                end
                `DCR_OFS_BIAS_CODE_HIGH: begin
                    state_next.bias_hi = wr_data_i;
                end
                default: begin
                    // read-only and unmapped offsets drop the write
                end
            endcase
        end
        if (rd_en_i) begin
            state_next.rd_valid = 1'b1;
            case (addr_i)
                `DCR_OFS_MAIN_CONTROL: begin
                    state_next.rd_data = state_reg.main_ctl;
                end
                `DCR_OFS_AUX_CONTROL: begin
                    state_next.rd_data = state_reg.aux_ctl;
                end
                `DCR_OFS_MOD_CODE_LOW: begin
                    state_next.rd_data = pad_pair(state_reg.mod_lo); // see R21
                end
                `DCR_OFS_MOD_CODE_HIGH: begin
                    state_next.rd_data = state_reg.mod_hi;
                end
                `DCR_OFS_BIAS_CODE_LOW: begin
                    state_next.rd_data = pad_pair(state_reg.bias_lo); // see R21
                end
                `DCR_OFS_BIAS_CODE_HIGH: begin
                    state_next.rd_data = state_reg.bias_hi;
                end
                `DCR_OFS_CONV_RESULT_HIGH: begin
                    state_next.rd_data = conv_result_i[9:2]; // see R20
                end
                `DCR_OFS_CONV_RESULT_LOW: begin
                    state_next.rd_data = pad_pair(conv_result_i[1:0]); // see R19
                end
                default: begin
                    state_next.rd_data = `DCR_RST_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    assign rd_data_o = state_reg.rd_data;
    assign rd_valid_o = state_reg.rd_valid;

    // ----------------------------------------
    // fault latch
    // ----------------------------------------
    assign flt.chip_on = state_reg.main_ctl[`DCR_BIT_CHIP_ON];
    assign flt.detect_on = state_reg.main_ctl[`DCR_BIT_FAULT_DETECT]; // see R4

    dcr_fault_latch u_fault (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .fault_pin_i(fault_pin_i),
        .flt(flt.mon)
    );

    // ----------------------------------------
    // run and shutdown
    // ----------------------------------------
    logic run;
    assign run = flt.chip_on && !flt.fault_latched; // see R1
    assign driver_run_o = run;
    assign fault_o = flt.fault_latched;
    assign output_stage_off_o = !run && state_reg.aux_ctl[`DCR_BIT_SHUTDOWN_STYLE]; // see R14
    assign signal_path_off_o = !run && !state_reg.aux_ctl[`DCR_BIT_SHUTDOWN_STYLE]; // see R14

    // ----------------------------------------
    // loop and monitor setup
    // ----------------------------------------
    assign photodiode_range_o = dcr_pd_range_e'(state_reg.main_ctl[`DCR_BIT_PD_RANGE_HI:`DCR_BIT_PD_RANGE_LO]); // see R2
    assign open_loop_o = state_reg.main_ctl[`DCR_BIT_OPEN_LOOP]; // see R3
    assign closed_loop_o = !state_reg.main_ctl[`DCR_BIT_OPEN_LOOP]; // see R3
    assign photodiode_orientation_o = state_reg.main_ctl[`DCR_BIT_PD_ORIENT]; // see R7

    // ----------------------------------------
    // signal path options
    // ----------------------------------------
    logic eq_on;
    assign eq_on = state_reg.main_ctl[`DCR_BIT_EQ_ON];
    assign output_invert_o = state_reg.main_ctl[`DCR_BIT_OUT_INVERT]; // see R5
    assign equalizer_on_o = eq_on; // see R6
    assign equalizer_bypass_o = !eq_on; // see R6
    assign equalizer_high_gain_o = eq_on && state_reg.aux_ctl[`DCR_BIT_EQ_HIGH_GAIN]; // see R10
    assign input_low_gain_o = !eq_on && state_reg.aux_ctl[`DCR_BIT_INPUT_LOW_GAIN]; // see R15
    assign offset_cancel_on_o = !state_reg.aux_ctl[`DCR_BIT_OFFSET_CANCEL_OFF]; // see R12

    // ----------------------------------------
    // drive options
    // ----------------------------------------
    assign serial_input_termination_o = state_reg.aux_ctl[`DCR_BIT_SER_TERM]; // see R8
    assign strong_follower_drive_o = state_reg.aux_ctl[`DCR_BIT_STRONG_FOLLOWER]; // see R9
    assign high_modulation_drive_o = state_reg.aux_ctl[`DCR_BIT_HIGH_MOD_DRIVE]; // see R11
    assign bias_sink_o = state_reg.aux_ctl[`DCR_BIT_BIAS_DIRECTION]; // see R13

    // ----------------------------------------
    // modulation code and swing
    // ----------------------------------------
    dcr_code_t mod_code;
    logic [12:0] mod_swing;
    assign mod_code = join_code(state_reg.mod_hi, state_reg.mod_lo); // see R16
    assign mod_swing = 13'(mod_code) * `DCR_MOD_STEP_HALF_MV;
    assign modulation_code_o = mod_code;
    // swing saturates at the top of the output range
    assign modulation_swing_half_mv_o = (mod_swing > `DCR_MOD_MAX_HALF_MV) ?
        `DCR_MOD_MAX_HALF_MV : mod_swing; // see R16

    // ----------------------------------------
    // bias code and targets
    // ----------------------------------------
    dcr_code_t bias_code;
    assign bias_code = join_code(state_reg.bias_hi, state_reg.bias_lo); // see R17
    assign bias_code_o = bias_code;

    // target counted in 0.75 uA units, coupling ratio applied downstream
    always_comb begin
        case (photodiode_range_o)
            DCR_PD_RANGE_770: begin
                closed_loop_target_steps_o = {2'b00, bias_code}; // see R17
            end
            DCR_PD_RANGE_1540: begin
                closed_loop_target_steps_o = {1'b0, bias_code, 1'b0}; // see R17
            end
            default: begin
                closed_loop_target_steps_o = {bias_code, 2'b00}; // see R17
            end
        endcase
    end

    assign open_loop_bias_ua_o = bias_sink_o ? ua_scale(bias_code, `DCR_OL_SINK_UA) :
        ua_scale(bias_code, `DCR_OL_SOURCE_UA); // see R18

endmodule

`default_nettype wire

// ===== verif/dcr_reg_bank_props.sv
`timescale 1ns/10ps
`default_nettype none

module dcr_reg_bank_props (
    // clock, reset and register port
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic rd_en_i,
    input wire logic [3:0] addr_i,
    input wire dcr_pkg::dcr_code_t conv_result_i,
    input wire logic [7:0] rd_data_o,
    input wire logic rd_valid_o,
    // run and setup outputs
    input wire logic fault_o,
    input wire logic driver_run_o,
    input wire logic output_stage_off_o,
    input wire logic signal_path_off_o,
    input wire dcr_pkg::dcr_pd_range_e photodiode_range_o,
    input wire logic open_loop_o,
    input wire logic closed_loop_o,
    input wire logic equalizer_on_o,
    input wire logic equalizer_bypass_o,
    input wire logic equalizer_high_gain_o,
    input wire logic input_low_gain_o,
    input wire logic bias_sink_o,
    // codes and targets
    input wire dcr_pkg::dcr_code_t modulation_code_o,
    input wire logic [12:0] modulation_swing_half_mv_o,
    input wire dcr_pkg::dcr_code_t bias_code_o,
    input wire logic [11:0] closed_loop_target_steps_o,
    input wire logic [17:0] open_loop_bias_ua_o
);
    import dcr_pkg::*;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_fault_stops: assert property (fault_o |-> !driver_run_o)
        else $error("driver runs with latched fault");
    chk_shut_style: assert property ((output_stage_off_o | signal_path_off_o) == !driver_run_o
        && !(output_stage_off_o && signal_path_off_o)) else $error("disable style wrong");
    chk_loop_pair: assert property (closed_loop_o == !open_loop_o)
        else $error("loop select outputs disagree");
    chk_eq_bypass: assert property (equalizer_bypass_o == !equalizer_on_o)
        else $error("equalizer bypass wrong");
    chk_eq_gain: assert property (equalizer_high_gain_o |-> equalizer_on_o)
        else $error("high gain without equalizer");
    chk_low_gain: assert property (input_low_gain_o |-> !equalizer_on_o)
        else $error("low gain with equalizer on");
    chk_mod_swing: assert property (int'(modulation_swing_half_mv_o) ==
        ((int'(modulation_code_o) * 5 > 4600) ? 4600 : int'(modulation_code_o) * 5))
        else $error("swing not code times step");
    chk_loop_target: assert property (int'(closed_loop_target_steps_o) == int'(bias_code_o)
        << ((photodiode_range_o >= DCR_PD_RANGE_3080) ? 2 : (photodiode_range_o == DCR_PD_RANGE_1540)))
        else $error("closed loop target wrong");
    chk_open_bias: assert property (int'(open_loop_bias_ua_o) ==
        int'(bias_code_o) * (bias_sink_o ? 100 : 150)) else $error("open loop bias wrong");
    chk_rd_pulse: assert property (rd_en_i && ce_i |=> rd_valid_o)
        else $error("read not answered");
    chk_conv_low: assert property (rd_en_i && ce_i && addr_i == 4'hF |=>
        rd_data_o == {6'h00, $past(conv_result_i[1:0])}) else $error("converter low bits wrong");
    chk_conv_high: assert property (rd_en_i && ce_i && addr_i == 4'hE |=>
        rd_data_o == $past(conv_result_i[9:2])) else $error("converter high bits wrong");
endmodule

`default_nettype wire

// ===== verif/dcr_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module dcr_host_model (
    input wire logic core_clk_i,
    output logic wr_en_o,
    output logic rd_en_o,
    output logic [3:0] addr_o,
    output logic [7:0] wr_data_o,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i
);
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = 4'h0;
        wr_data_o = 8'h00;
    end

    // released lines show inverted values, never the old ones
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_en_o <= 1'b1;
        addr_o <= a;
        wr_data_o <= d;
        @(posedge core_clk_i);
        wr_en_o <= 1'b0;
        addr_o <= ~a;
        wr_data_o <= ~d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic v);
        @(posedge core_clk_i);
        rd_en_o <= 1'b1;
        addr_o <= a;
        @(posedge core_clk_i);
        rd_en_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rd_data_i;
        v = rd_valid_i;
    endtask
endmodule

`default_nettype wire

// ===== verif/dcr_reg_bank_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module dcr_reg_bank_tb_top;
    import dcr_pkg::*;
    logic core_clk_i, sys_rst_i, ce_i, wr_en_i, rd_en_i, rd_valid_o, fault_pin_i, fault_o, driver_run_o;
    logic output_stage_off_o, signal_path_off_o, open_loop_o, closed_loop_o, photodiode_orientation_o;
    logic output_invert_o, equalizer_on_o, equalizer_bypass_o, equalizer_high_gain_o, input_low_gain_o;
    logic offset_cancel_on_o, serial_input_termination_o, strong_follower_drive_o;
    logic high_modulation_drive_o, bias_sink_o;
    logic [3:0] addr_i;
    logic [7:0] wr_data_i, rd_data_o;
    dcr_code_t conv_result_i, modulation_code_o, bias_code_o;
    dcr_pd_range_e photodiode_range_o;
    logic [12:0] modulation_swing_half_mv_o;
    logic [11:0] closed_loop_target_steps_o;
    logic [17:0] open_loop_bias_ua_o;
    logic [18:0] act_flags;
    logic [7:0] m [6];
    logic [7:0] nofault [2] = '{8'h80, 8'h08};
    int mismatches = 0;
    int num_checks = 0;
    integer seed = 69;

    dcr_reg_bank dut (.core_clk_i, .sys_rst_i, .ce_i, .wr_en_i, .rd_en_i, .addr_i, .wr_data_i, .rd_data_o,
        .rd_valid_o, .conv_result_i, .fault_pin_i, .driver_run_o, .fault_o, .output_stage_off_o,
        .signal_path_off_o, .photodiode_range_o, .open_loop_o, .closed_loop_o, .photodiode_orientation_o,
        .output_invert_o, .equalizer_on_o, .equalizer_bypass_o, .equalizer_high_gain_o, .input_low_gain_o,
        .offset_cancel_on_o, .serial_input_termination_o, .strong_follower_drive_o, .high_modulation_drive_o,
        .bias_sink_o, .modulation_code_o, .modulation_swing_half_mv_o, .bias_code_o,
        .closed_loop_target_steps_o, .open_loop_bias_ua_o);
    dcr_host_model host (.core_clk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
        .wr_data_o(wr_data_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o));

    assign act_flags = {driver_run_o, fault_o, output_stage_off_o, signal_path_off_o, photodiode_range_o,
        open_loop_o, closed_loop_o, photodiode_orientation_o, output_invert_o, equalizer_on_o,
        equalizer_bypass_o, equalizer_high_gain_o, input_low_gain_o, offset_cancel_on_o,
        serial_input_termination_o, strong_follower_drive_o, high_modulation_drive_o, bias_sink_o};

    // ----------------------------------------
    // expectations and checks
    // ----------------------------------------
    function automatic logic [18:0] exp_flags(input logic f);
        logic run;
        run = m[0][7] & ~f;
        return {run, f, ~run & m[1][1], ~run & ~m[1][1], m[0][6:5], m[0][4], ~m[0][4], m[0][0], m[0][2],
            m[0][1], ~m[0][1], m[1][5] & m[0][1], m[1][0] & ~m[0][1], ~m[1][3], m[1][7], m[1][6], m[1][4],
            m[1][2]};
    endfunction

    function automatic logic [7:0] exp_rd(input logic [3:0] a);
        if (a < 4'h6) return m[a];
        if (a == 4'hE) return conv_result_i[9:2];
        if (a == 4'hF) return {6'h00, conv_result_i[1:0]};
        return 8'h00;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrm(input logic [3:0] a, input logic [7:0] d);
        host.wr(a, d);
        #1;
        if (a < 4'h6) m[a] = (a == 4'h2 || a == 4'h4) ? (d & 8'h03) : d;
    endtask

    task automatic rdchk(input logic [3:0] a);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        cmp({23'h0, v, d}, {24'h00_0001, exp_rd(a)});
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog and sequence
    // ----------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    initial begin
        repeat (20000) @(posedge core_clk_i);
        mismatches++;
        wrap_up();
    end

    initial begin
        sys_rst_i = 1'b1;
        ce_i = 1'b1;
        fault_pin_i = 1'b0;
        conv_result_i = 10'h000;
        for (int i = 0; i < 6; i++) m[i] = 8'h00;
        repeat (20) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        #1;
        cmp(act_flags, exp_flags(1'b0));
        for (int i = 0; i < 16; i++) rdchk(4'(i));
        wrm(4'h3, 8'hFF);
        wrm(4'h2, 8'hFF);
        cmp(modulation_code_o, 10'h3FF);
        for (int n = 0; n < 300; n++) begin
            @(posedge core_clk_i);
            conv_result_i <= 10'($random(seed));
            wrm(4'($random(seed)), 8'($random(seed)));
            cmp(act_flags, exp_flags(1'b0));
            cmp({modulation_code_o, bias_code_o}, {m[3], m[2][1:0], m[5], m[4][1:0]});
            rdchk(4'($random(seed)));
        end
        wrm(4'h0, 8'h88);
        @(posedge core_clk_i);
        fault_pin_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1;
        cmp(act_flags, exp_flags(1'b1));
        @(posedge core_clk_i);
        fault_pin_i <= 1'b0;
        wrm(4'h0, 8'h08);
        @(posedge core_clk_i);
        #1;
        cmp(act_flags, exp_flags(1'b0));
        wrm(4'h0, 8'h88);
        cmp(act_flags, exp_flags(1'b0));
        foreach (nofault[k]) begin
            wrm(4'h0, nofault[k]);
            @(posedge core_clk_i);
            fault_pin_i <= 1'b1;
            repeat (5) @(posedge core_clk_i);
            #1;
            cmp(act_flags, exp_flags(1'b0));
            @(posedge core_clk_i);
            fault_pin_i <= 1'b0;
        end
        // clock enable low must drop a write and freeze every register
        @(posedge core_clk_i);
        ce_i <= 1'b0;
        host.wr(4'h0, 8'h80);
        @(posedge core_clk_i);
        #1;
        cmp(act_flags, exp_flags(1'b0));
        @(posedge core_clk_i);
        ce_i <= 1'b1;
        rdchk(4'h0);
        wrap_up();
    end
endmodule

bind dcr_reg_bank dcr_reg_bank_props chk (.core_clk_i, .sys_rst_i, .ce_i, .rd_en_i, .addr_i, .conv_result_i,
    .rd_data_o, .rd_valid_o, .fault_o, .driver_run_o, .output_stage_off_o, .signal_path_off_o,
    .photodiode_range_o, .open_loop_o, .closed_loop_o, .equalizer_on_o, .equalizer_bypass_o,
    .equalizer_high_gain_o, .input_low_gain_o, .bias_sink_o, .modulation_code_o, .modulation_swing_half_mv_o,
    .bias_code_o, .closed_loop_target_steps_o, .open_loop_bias_ua_o);

`default_nettype wire
